// ---- rtl/vdc_pkg.sv ----
// Constants, field layout and state codes for the decoder configuration bank.
package vdc_pkg;

   // ----------------------------------------------------------------
   // Serial bus and register map
   // ----------------------------------------------------------------
   localparam logic [7:0] VDC_DEV_WR_ADDR   = 8'h88;
   localparam logic [7:0] VDC_IDX_INPUT_STD = 8'h00;
   localparam logic [7:0] VDC_IDX_OUT_FMT   = 8'h01;
   localparam logic [7:0] VDC_IDX_OUT_PIN   = 8'h02;
   localparam logic [7:0] VDC_IDX_SEP_AGC   = 8'h03;
   localparam logic [7:0] VDC_IDX_GAIN_RATE = 8'h04;
   localparam int         VDC_NUM_REGS      = 5;
   localparam logic [7:0] VDC_REG_RESET     = 8'h00;
   localparam logic [3:0] VDC_BITS_PER_BYTE = 4'h8;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int F_SUBCARRIER = 0;
   localparam int F_COLOUR_SYS = 2;
   localparam int F_LINE_COUNT = 3;
   localparam int F_IN_CHANNEL = 4;
   localparam int F_PIC_SIZE   = 0;
   localparam int F_OUT_LIMIT  = 3;
   localparam int F_IF_MODE    = 4;
   localparam int F_VBIT_LINE  = 6;
   localparam int F_VPULSE     = 7;
   localparam int F_HSYNC_POL  = 0;
   localparam int F_VSYNC_POL  = 1;
   localparam int F_VALID_POL  = 2;
   localparam int F_CLK_INV    = 3;
   localparam int F_SYNC_EN    = 4;
   localparam int F_VALID_EN   = 5;
   localparam int F_NOSIG_SEL  = 6;
   localparam int F_SEP_METHOD = 0;
   localparam int F_KILL_TRIG  = 1;
   localparam int F_AGC_CORE   = 3;
   localparam int F_AGC_SPEED  = 5;
   localparam int F_VPIN_FUNC  = 6;
   localparam int F_AGC_EN     = 0;
   localparam int F_ACC_EN     = 1;
   localparam int F_KILL_DIS   = 2;
   localparam int F_FRAME_RATE = 3;
   localparam int F_FIELD_CHC  = 5;
   localparam int F_NOSIG_DEF  = 6;
   localparam int F_CONTRAST   = 7;

   // ----------------------------------------------------------------
   // Field codes and output levels
   // ----------------------------------------------------------------
   localparam logic [2:0] PIC_601      = 3'h6;
   localparam logic [1:0] IF_CAM_PLAIN = 2'h0;
   localparam logic [1:0] IF_CAM_CODES = 2'h1;
   localparam logic [1:0] IF_SYNC      = 2'h2;
   localparam logic [1:0] IF_BT656     = 2'h3;
   localparam logic [1:0] NS_BLACK     = 2'h0;
   localparam logic [1:0] NS_BLUE      = 2'h1;
   localparam logic [1:0] NS_RAW       = 2'h2;
   localparam logic [1:0] RATE_FULL    = 2'h0;
   localparam logic [7:0] BLACK_LUMA   = 8'h10;
   localparam logic [7:0] BLACK_CHROMA = 8'h80;
   localparam logic [7:0] BLUE_LUMA    = 8'h29;
   localparam logic [7:0] BLUE_CB      = 8'hF0;
   localparam logic [7:0] BLUE_CR      = 8'h6E;
   localparam logic [7:0] WIDE_MIN     = 8'h01;
   localparam logic [7:0] WIDE_MAX     = 8'hFE;
   localparam logic [7:0] NARROW_MIN   = 8'h10;
   localparam logic [7:0] LUMA_MAX_601 = 8'hEB;
   localparam logic [7:0] CHROMA_MAX_601 = 8'hF0;

   // ----------------------------------------------------------------
   // Serial slave states
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE     = 4'h0,
      ST_ADDR     = 4'h1,
      ST_ADDR_ACK = 4'h3,
      ST_SUB      = 4'h2,
      ST_SUB_ACK  = 4'h6,
      ST_WR       = 4'h7,
      ST_WR_ACK   = 4'h5,
      ST_RD       = 4'h4,
      ST_RD_ACK   = 4'hC
   } vdc_state_type;

endpackage : vdc_pkg

// ---- rtl/vdc_cfg_regs.sv ----
// Configuration register bank of the video decoder with its serial slave.
`timescale 1ns/1ns

module vdc_cfg_regs
   import vdc_pkg::*;
(
   input  wire logic       CLK_IN,
   input  wire logic       SYS_RST_IN,
   input  wire logic       SCL_IN,
   input  wire logic       SDA_IN,
   output logic            SDA_OUT,
   output logic            SDA_OE_OUT,
   output logic [1:0]      SUBCARRIER_SEL_OUT,
   output logic            COLOUR_PAL_OUT,
   output logic            LINES_625_OUT,
   output logic            INPUT_CHANNEL_OUT,
   output logic [2:0]      PICTURE_SIZE_OUT,
   output logic [1:0]      INTERFACE_MODE_OUT,
   output logic [7:0]      LIMIT_MIN_OUT,
   output logic [7:0]      LUMA_MAX_OUT,
   output logic [7:0]      CHROMA_MAX_OUT,
   output logic            VBIT_LONG_OUT,
   output logic            VPULSE_ON_SKIPPED_OUT,
   output logic            HSYNC_POLARITY_OUT,
   output logic            VSYNC_POLARITY_OUT,
   output logic            VALID_POLARITY_OUT,
   output logic            OUT_CLOCK_INVERT_OUT,
   output logic            SYNC_PINS_DRIVE_OUT,
   output logic            VALID_PIN_DRIVE_OUT,
   output logic [7:0]      NOSIG_LUMA_OUT,
   output logic [7:0]      NOSIG_CB_OUT,
   output logic [7:0]      NOSIG_CR_OUT,
   output logic            NOSIG_PASS_RAW_OUT,
   output logic            CHROMA_2D_COMB_OUT,
   output logic [1:0]      KILLER_TRIGGER_OUT,
   output logic [1:0]      AGC_CORING_OUT,
   output logic            AGC_SLOW_OUT,
   output logic            VPIN_FIELD_OUT,
   output logic            AGC_ENABLE_OUT,
   output logic            ACC_ENABLE_OUT,
   output logic            KILLER_ENABLE_OUT,
   output logic [1:0]      FRAME_RATE_OUT,
   output logic            FIELD_EVEN_OUT,
   output logic            NOSIG_VSYNC_ONLY_OUT,
   output logic            CONTRAST_BLACK_OUT
);

   // ----------------------------------------------------------------
   // Serial line sampling
   // ----------------------------------------------------------------
   logic          scl_q;
   logic          sda_q;
   logic          scl_rise;
   logic          scl_fall;
   logic          bus_start;
   logic          bus_stop;
   vdc_state_type state_q;
   logic [3:0]    bit_cnt_q;
   logic [7:0]    shift_q;
   logic [7:0]    ptr_q;
   logic [7:0]    tx_q;
   logic          read_q;
   logic          sda_oe_q;
   logic [7:0]    regs_q [VDC_NUM_REGS];
   logic [7:0]    rd_data;
   logic          byte_done;
   logic          wr_fire;
   logic          addr_match;

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= SCL_IN;
         sda_q <= SDA_IN;
      end
   end

   assign scl_rise   = SCL_IN & ~scl_q;
   assign scl_fall   = ~SCL_IN & scl_q;
   assign bus_start  = SCL_IN & scl_q & sda_q & ~SDA_IN;
   assign bus_stop   = SCL_IN & scl_q & ~sda_q & SDA_IN;
   assign byte_done  = scl_fall & (bit_cnt_q == VDC_BITS_PER_BYTE);
   assign addr_match = (shift_q[7:1] == VDC_DEV_WR_ADDR[7:1]);
   assign wr_fire    = (state_q == ST_WR) & byte_done;

   always_comb begin
      rd_data = VDC_REG_RESET;
      if (ptr_q < 8'(VDC_NUM_REGS)) begin
         rd_data = regs_q[ptr_q[2:0]];
      end
   end

   // ----------------------------------------------------------------
   // Serial slave sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         state_q   <= ST_IDLE;
         bit_cnt_q <= 4'h0;
         shift_q   <= 8'h00;
         read_q    <= 1'b0;
      end else if (bus_stop) begin
         state_q <= ST_IDLE;
      end else if (bus_start) begin
         state_q   <= ST_ADDR;
         bit_cnt_q <= 4'h0;
      end else begin
         if (scl_rise) begin
            shift_q   <= {shift_q[6:0], SDA_IN};
            bit_cnt_q <= bit_cnt_q + 4'h1;
         end
         unique case (state_q)
            ST_IDLE: begin
            end
            ST_ADDR: begin
               if (byte_done) begin
                  state_q <= addr_match ? ST_ADDR_ACK : ST_IDLE;
                  read_q  <= shift_q[0];
               end
            end
            ST_ADDR_ACK: begin
               if (scl_fall) begin
                  state_q   <= read_q ? ST_RD : ST_SUB;
                  bit_cnt_q <= 4'h0;
               end
            end
            ST_SUB: begin
               if (byte_done) begin
                  state_q <= ST_SUB_ACK;
               end
            end
            ST_SUB_ACK: begin
               if (scl_fall) begin
                  state_q   <= ST_WR;
                  bit_cnt_q <= 4'h0;
               end
            end
            ST_WR: begin
               if (byte_done) begin
                  state_q <= ST_WR_ACK;
               end
            end
            ST_WR_ACK: begin
               if (scl_fall) begin
                  state_q   <= ST_WR;
                  bit_cnt_q <= 4'h0;
               end
            end
            ST_RD: begin
               if (byte_done) begin
                  state_q <= ST_RD_ACK;
               end
            end
            ST_RD_ACK: begin
               if (scl_rise && SDA_IN) begin
                  state_q <= ST_IDLE;
               end else if (scl_fall) begin
                  state_q   <= ST_RD;
                  bit_cnt_q <= 4'h0;
               end
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // sub-address load and increment per written data byte
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         ptr_q <= 8'h00;
      end else if ((state_q == ST_SUB) && byte_done) begin
         ptr_q <= shift_q;
      end else if (wr_fire) begin
         ptr_q <= ptr_q + 8'h01;
      end
   end

   // A repeated read keeps sending the first byte, so the pointer stays.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         tx_q <= 8'h00;
      end else if (scl_fall && (state_q == ST_ADDR_ACK ||
                                state_q == ST_RD_ACK)) begin
         tx_q <= rd_data;
      end else if (scl_fall && state_q == ST_RD) begin
         tx_q <= {tx_q[6:0], 1'b0};
      end
   end

   // The pin is open drain: it is only ever pulled low.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN || bus_stop || bus_start) begin
         sda_oe_q <= 1'b0;
      end else if (scl_fall) begin
         unique case (state_q)
            ST_ADDR:     sda_oe_q <= byte_done & addr_match;
            ST_SUB:      sda_oe_q <= byte_done;
            ST_WR:       sda_oe_q <= byte_done;
            ST_ADDR_ACK: sda_oe_q <= read_q & ~rd_data[7];
            ST_RD_ACK:   sda_oe_q <= ~rd_data[7];
            ST_RD:       sda_oe_q <= ~byte_done & ~tx_q[6];
            default:     sda_oe_q <= 1'b0;
         endcase
      end
   end

   always_ff @(posedge CLK_IN) begin
      SDA_OUT <= 1'b0;
   end

   assign SDA_OE_OUT = sda_oe_q;

   // ----------------------------------------------------------------
   // Register storage
   // ----------------------------------------------------------------
   for (genvar i = 0; i < VDC_NUM_REGS; i++) begin : g_reg
      always_ff @(posedge CLK_IN) begin
         if (SYS_RST_IN) begin
            regs_q[i] <= VDC_REG_RESET;
         end else if (wr_fire && ptr_q == 8'(i)) begin
            regs_q[i] <= shift_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Plain field outputs
   // ----------------------------------------------------------------
   // subcarrier choice
   assign SUBCARRIER_SEL_OUT = regs_q[0][F_SUBCARRIER +: 2];
   assign COLOUR_PAL_OUT     = regs_q[0][F_COLOUR_SYS];
   assign LINES_625_OUT      = regs_q[0][F_LINE_COUNT];
   assign INPUT_CHANNEL_OUT  = regs_q[0][F_IN_CHANNEL];
   assign PICTURE_SIZE_OUT   = regs_q[1][F_PIC_SIZE +: 3];
   assign INTERFACE_MODE_OUT = regs_q[1][F_IF_MODE +: 2];
   assign HSYNC_POLARITY_OUT = regs_q[2][F_HSYNC_POL];
   assign VSYNC_POLARITY_OUT = regs_q[2][F_VSYNC_POL];
   assign VALID_POLARITY_OUT = regs_q[2][F_VALID_POL];
   assign OUT_CLOCK_INVERT_OUT = regs_q[2][F_CLK_INV];
   assign KILLER_TRIGGER_OUT = regs_q[3][F_KILL_TRIG +: 2];
   assign AGC_CORING_OUT     = regs_q[3][F_AGC_CORE +: 2];
   assign AGC_SLOW_OUT       = regs_q[3][F_AGC_SPEED];
   assign AGC_ENABLE_OUT     = regs_q[4][F_AGC_EN];
   assign ACC_ENABLE_OUT     = regs_q[4][F_ACC_EN];
   assign FRAME_RATE_OUT     = regs_q[4][F_FRAME_RATE +: 2];
   assign FIELD_EVEN_OUT     = regs_q[4][F_FIELD_CHC];
   assign NOSIG_VSYNC_ONLY_OUT = regs_q[4][F_NOSIG_DEF];
   assign CONTRAST_BLACK_OUT = regs_q[4][F_CONTRAST];

   // ----------------------------------------------------------------
   // Derived controls, one cycle behind the registers
   // ----------------------------------------------------------------
   logic [1:0] if_mode;
   logic [2:0] pic_size;
   logic       code_mode;

   assign if_mode   = regs_q[1][F_IF_MODE +: 2];
   assign pic_size  = regs_q[1][F_PIC_SIZE +: 3];
   assign code_mode = (if_mode == IF_CAM_CODES) | (if_mode == IF_BT656);

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         SYNC_PINS_DRIVE_OUT <= 1'b0;
         VALID_PIN_DRIVE_OUT <= 1'b0;
      end else begin
         // code-carrying modes hold pins low unless enabled
         SYNC_PINS_DRIVE_OUT <= code_mode ? regs_q[2][F_SYNC_EN] : 1'b1;
         VALID_PIN_DRIVE_OUT <= code_mode ? regs_q[2][F_VALID_EN] : 1'b1;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         LIMIT_MIN_OUT  <= WIDE_MIN;
         LUMA_MAX_OUT   <= WIDE_MAX;
         CHROMA_MAX_OUT <= WIDE_MAX;
      end else if (regs_q[1][F_OUT_LIMIT]) begin
         LIMIT_MIN_OUT  <= NARROW_MIN;
         LUMA_MAX_OUT   <= LUMA_MAX_601;
         CHROMA_MAX_OUT <= CHROMA_MAX_601;
      end else begin
         LIMIT_MIN_OUT  <= WIDE_MIN;
         LUMA_MAX_OUT   <= WIDE_MAX;
         CHROMA_MAX_OUT <= WIDE_MAX;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         VBIT_LONG_OUT         <= 1'b0;
         VPULSE_ON_SKIPPED_OUT <= 1'b0;
         VPIN_FIELD_OUT        <= 1'b0;
         KILLER_ENABLE_OUT     <= 1'b1;
         CHROMA_2D_COMB_OUT    <= 1'b0;
      end else begin
         // longer V interval only for 601 with 525 lines
         VBIT_LONG_OUT <= regs_q[1][F_VBIT_LINE] &
                          (pic_size == PIC_601) & ~regs_q[0][F_LINE_COUNT];
         // pulses on skipped frames in sync or BT.656 mode
         VPULSE_ON_SKIPPED_OUT <= regs_q[1][F_VPULSE] & if_mode[1] &
            (regs_q[4][F_FRAME_RATE +: 2] != RATE_FULL);
         // camera modes always carry the active flag
         VPIN_FIELD_OUT <= regs_q[3][F_VPIN_FUNC] & if_mode[1];
         KILLER_ENABLE_OUT <= ~regs_q[4][F_KILL_DIS];
         // 2D comb only for NTSC with reduced formats
         CHROMA_2D_COMB_OUT <= regs_q[3][F_SEP_METHOD] &
            ~regs_q[0][F_COLOUR_SYS] & (pic_size != PIC_601) &
            (pic_size != 3'h1) & (pic_size != 3'h7);
      end
   end

   // Blue has no fixed code, so the fill level is a package choice.
   always_ff @(posedge CLK_IN) begin
      if (SYS_RST_IN) begin
         NOSIG_LUMA_OUT     <= BLACK_LUMA;
         NOSIG_CB_OUT       <= BLACK_CHROMA;
         NOSIG_CR_OUT       <= BLACK_CHROMA;
         NOSIG_PASS_RAW_OUT <= 1'b0;
      end else begin
         NOSIG_PASS_RAW_OUT <= (regs_q[2][F_NOSIG_SEL +: 2] == NS_RAW);
         if (regs_q[2][F_NOSIG_SEL +: 2] == NS_BLUE) begin
            NOSIG_LUMA_OUT <= BLUE_LUMA;
            NOSIG_CB_OUT   <= BLUE_CB;
            NOSIG_CR_OUT   <= BLUE_CR;
         end else begin
            NOSIG_LUMA_OUT <= BLACK_LUMA;
            NOSIG_CB_OUT   <= BLACK_CHROMA;
            NOSIG_CR_OUT   <= BLACK_CHROMA;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_addr_byte;
      (state_q == ST_ADDR) && byte_done && addr_match;
   endsequence

   sequence s_ack_held;
      sda_oe_q [*1] ##1 (state_q == ST_ADDR_ACK);
   endsequence

   a_addr_ack_drive: assert property (
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      s_addr_byte |=> s_ack_held)
      else $error("address byte not acknowledged");

   a_write_lands: assert property (
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      wr_fire && ptr_q == 8'h02 |=> regs_q[2] == $past(shift_q))
      else $error("written byte not stored");

   a_ptr_advance: assert property (
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      wr_fire |=> ptr_q == $past(ptr_q) + 8'h01)
      else $error("sub-address did not advance");

   a_sync_hold_low: assert property (
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      code_mode && !regs_q[2][F_SYNC_EN] |=> !SYNC_PINS_DRIVE_OUT)
      else $error("sync pins driven in code mode");

   a_killer_invert: assert property (
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      regs_q[4][F_KILL_DIS] ##1 regs_q[4][F_KILL_DIS] |-> !KILLER_ENABLE_OUT)
      else $error("colour killer not disabled");

   a_vpin_camera: assert property (
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      !if_mode[1] |=> !VPIN_FIELD_OUT)
      else $error("field on vertical pin in camera mode");

   a_black_fill: assert property (
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      regs_q[2][F_NOSIG_SEL +: 2] == NS_BLACK |=>
         NOSIG_LUMA_OUT == 8'h10 && NOSIG_CB_OUT == 8'h80)
      else $error("black fill level wrong");

   a_limit_range: assert property (
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      regs_q[1][F_OUT_LIMIT] |=> LUMA_MAX_OUT == 8'hEB &&
         CHROMA_MAX_OUT == 8'hF0 && LIMIT_MIN_OUT == 8'h10)
      else $error("clip bounds wrong");

   a_vbit_601_only: assert property (
      @(posedge CLK_IN) disable iff (SYS_RST_IN)
      pic_size != PIC_601 |=> !VBIT_LONG_OUT)
      else $error("long V interval outside 601 size");

endmodule : vdc_cfg_regs

// ---- tb/vdc_host_model.sv ----
// Host controller model that drives the two-wire configuration bus.
`timescale 1ns/1ns
module vdc_host_model
   import vdc_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_low_out
);
   // ----------------------------------------------------------------
   // Bit and byte level
   // ----------------------------------------------------------------
   initial begin
      scl_out     = 1'b1;
      sda_low_out = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick

   // Each phase lasts several clocks so the slave's sampler never misses it.
   task automatic bit_cycle(input logic low, output logic seen);
      sda_low_out <= low;
      tick(4);
      scl_out <= 1'b1;
      tick(2);
      seen = sda_in;
      tick(2);
      scl_out <= 1'b0;
      tick(2);
   endtask : bit_cycle

   task automatic start_cond();
      sda_low_out <= 1'b0;
      tick(4);
      scl_out <= 1'b1;
      tick(4);
      sda_low_out <= 1'b1;
      tick(4);
      scl_out <= 1'b0;
      tick(2);
   endtask : start_cond

   task automatic stop_cond();
      sda_low_out <= 1'b1;
      tick(4);
      scl_out <= 1'b1;
      tick(4);
      sda_low_out <= 1'b0;
      tick(4);
   endtask : stop_cond

   task automatic put_byte(input logic [7:0] b, output logic ack);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(~b[i], seen);
      end
      bit_cycle(1'b0, seen);
      ack = ~seen;
   endtask : put_byte

   task automatic get_byte(input logic last, output logic [7:0] b);
      logic seen;
      for (int i = 7; i >= 0; i--) begin
         bit_cycle(1'b0, seen);
         b[i] = seen;
      end
      bit_cycle(~last, seen);
   endtask : get_byte

   // ----------------------------------------------------------------
   // Transfers
   // ----------------------------------------------------------------
   // address, sub-address, data
   task automatic write_seq(input logic [7:0] dev, input logic [7:0] sub,
                            input logic [7:0] q[$], output logic ok);
      logic a;
      start_cond();
      put_byte(dev, ok);
      put_byte(sub, a);
      ok = ok & a;
      foreach (q[i]) begin
         put_byte(q[i], a);
         ok = ok & a;
      end
      stop_cond();
   endtask : write_seq

   task automatic read_seq(input logic [7:0] sub, input int n,
                           output logic [7:0] q[$]);
      logic       a;
      logic [7:0] b;
      q = {};
      start_cond();
      put_byte(VDC_DEV_WR_ADDR, a);
      put_byte(sub, a);
      start_cond();
      put_byte(VDC_DEV_WR_ADDR | 8'h01, a);
      for (int i = 0; i < n; i++) begin
         get_byte(i == n - 1, b);
         q.push_back(b);
      end
      stop_cond();
   endtask : read_seq
endmodule : vdc_host_model

// ---- tb/video_decoder_config_regs_tb.sv ----
// Self-checking bench for the decoder configuration bank.
`timescale 1ns/1ns
module video_decoder_config_regs_tb
   import vdc_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals, design and host
   // ----------------------------------------------------------------
   logic CLK_IN = 1'b0, SYS_RST_IN = 1'b1, SCL_IN, SDA_IN, SDA_OUT, SDA_OE_OUT;
   logic COLOUR_PAL_OUT, LINES_625_OUT, INPUT_CHANNEL_OUT, VBIT_LONG_OUT;
   logic VPULSE_ON_SKIPPED_OUT, HSYNC_POLARITY_OUT, VSYNC_POLARITY_OUT;
   logic VALID_POLARITY_OUT, OUT_CLOCK_INVERT_OUT, SYNC_PINS_DRIVE_OUT;
   logic VALID_PIN_DRIVE_OUT, NOSIG_PASS_RAW_OUT, CHROMA_2D_COMB_OUT;
   logic AGC_SLOW_OUT, VPIN_FIELD_OUT, AGC_ENABLE_OUT, ACC_ENABLE_OUT;
   logic KILLER_ENABLE_OUT, FIELD_EVEN_OUT, NOSIG_VSYNC_ONLY_OUT;
   logic CONTRAST_BLACK_OUT, host_sda_low, ok;
   logic [1:0] SUBCARRIER_SEL_OUT, INTERFACE_MODE_OUT, KILLER_TRIGGER_OUT;
   logic [1:0] AGC_CORING_OUT, FRAME_RATE_OUT;
   logic [2:0] PICTURE_SIZE_OUT;
   logic [7:0] LIMIT_MIN_OUT, LUMA_MAX_OUT, CHROMA_MAX_OUT, NOSIG_LUMA_OUT;
   logic [7:0] NOSIG_CB_OUT, NOSIG_CR_OUT;
   logic [7:0] r [5];
   int         errors = 0, samples_checked = 0, cycles = 0;

   // The line idles high through its pull-up whenever nobody pulls it low.
   assign SDA_IN = ~(SDA_OE_OUT | host_sda_low);
   always #10 CLK_IN = ~CLK_IN;

   vdc_cfg_regs dut_u (.CLK_IN, .SYS_RST_IN, .SCL_IN, .SDA_IN, .SDA_OUT,
      .SDA_OE_OUT, .SUBCARRIER_SEL_OUT, .COLOUR_PAL_OUT, .LINES_625_OUT,
      .INPUT_CHANNEL_OUT, .PICTURE_SIZE_OUT, .INTERFACE_MODE_OUT,
      .LIMIT_MIN_OUT, .LUMA_MAX_OUT, .CHROMA_MAX_OUT, .VBIT_LONG_OUT,
      .VPULSE_ON_SKIPPED_OUT, .HSYNC_POLARITY_OUT, .VSYNC_POLARITY_OUT,
      .VALID_POLARITY_OUT, .OUT_CLOCK_INVERT_OUT, .SYNC_PINS_DRIVE_OUT,
      .VALID_PIN_DRIVE_OUT, .NOSIG_LUMA_OUT, .NOSIG_CB_OUT, .NOSIG_CR_OUT,
      .NOSIG_PASS_RAW_OUT, .CHROMA_2D_COMB_OUT, .KILLER_TRIGGER_OUT,
      .AGC_CORING_OUT, .AGC_SLOW_OUT, .VPIN_FIELD_OUT, .AGC_ENABLE_OUT,
      .ACC_ENABLE_OUT, .KILLER_ENABLE_OUT, .FRAME_RATE_OUT, .FIELD_EVEN_OUT,
      .NOSIG_VSYNC_ONLY_OUT, .CONTRAST_BLACK_OUT);

   vdc_host_model host_u (.clk_in(CLK_IN), .sda_in(SDA_IN),
      .scl_out(SCL_IN), .sda_low_out(host_sda_low));

   // ----------------------------------------------------------------
   // Checking helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic print_verdict();
      if (errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   function automatic logic drive_exp(logic [1:0] md, logic en);
      return md[0] ? en : 1'b1;
   endfunction : drive_exp

   function automatic logic [23:0] nosig_exp(logic [1:0] code);
      return (code == 2'h1) ? {BLUE_LUMA, BLUE_CB, BLUE_CR} : 24'h108080;
   endfunction : nosig_exp

   // reserved codes and bits stay clear
   function automatic void legalise();
      if (r[1][2:0] == 3'h7) r[1][2] = 1'b0;
      if (r[2][7:6] == 2'h3) r[2][7] = 1'b0;
      if (r[3][2:1] == 2'h3) r[3][2] = 1'b0;
      if (r[4][4:3] == 2'h3) r[4][4] = 1'b0;
      r[0][7:5] = 3'h0;
      r[3][7]   = 1'b0;
   endfunction : legalise

   task automatic check_all();
      logic [2:0] sz;
      logic [1:0] md;
      sz = r[1][2:0];
      md = r[1][5:4];
      repeat (2) @(posedge CLK_IN);
      @(negedge CLK_IN);
      check({INPUT_CHANNEL_OUT, LINES_625_OUT, COLOUR_PAL_OUT,
             SUBCARRIER_SEL_OUT}, r[0][4:0]);
      check({SDA_OUT, SDA_OE_OUT}, 2'h0);
      check({PICTURE_SIZE_OUT, INTERFACE_MODE_OUT}, {sz, md});
      check({LIMIT_MIN_OUT, LUMA_MAX_OUT, CHROMA_MAX_OUT},
            r[1][3] ? 24'h10EBF0 : 24'h01FEFE);
      check({SYNC_PINS_DRIVE_OUT, VALID_PIN_DRIVE_OUT},
            {drive_exp(md, r[2][4]), drive_exp(md, r[2][5])});
      check(VBIT_LONG_OUT, r[1][6] & (sz == 3'h6) & ~r[0][3]);
      check(VPULSE_ON_SKIPPED_OUT, r[1][7] & md[1] & |r[4][4:3]);
      check({OUT_CLOCK_INVERT_OUT, VALID_POLARITY_OUT, VSYNC_POLARITY_OUT,
             HSYNC_POLARITY_OUT}, r[2][3:0]);
      check({NOSIG_LUMA_OUT, NOSIG_CB_OUT, NOSIG_CR_OUT, NOSIG_PASS_RAW_OUT},
            {nosig_exp(r[2][7:6]), r[2][7:6] == 2'h2});
      check(CHROMA_2D_COMB_OUT,
            r[3][0] & ~r[0][2] & (sz != 3'h1) & (sz != 3'h6));
      check({AGC_SLOW_OUT, AGC_CORING_OUT, KILLER_TRIGGER_OUT},
            r[3][5:1]);
      check(VPIN_FIELD_OUT, r[3][6] & md[1]);
      check({KILLER_ENABLE_OUT, ACC_ENABLE_OUT, AGC_ENABLE_OUT},
            {~r[4][2], r[4][1:0]});
      check({CONTRAST_BLACK_OUT, NOSIG_VSYNC_ONLY_OUT, FIELD_EVEN_OUT,
             FRAME_RATE_OUT}, r[4][7:3]);
   endtask : check_all

   // A two-byte read must repeat the first byte; place 5 reads as zero.
   task automatic read_check(input int idx);
      logic [7:0] q[$];
      logic [7:0] e;
      e = (idx < 5) ? r[idx] : 8'h00;
      host_u.read_seq(8'(idx), 2, q);
      check({q[0], q[1]}, {e, e});
   endtask : read_check

   // ----------------------------------------------------------------
   // Sequence and timeout
   // ----------------------------------------------------------------
   always @(posedge CLK_IN) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         errors++;
         print_verdict();
      end
   end

   initial begin
      void'($urandom(32'h59BB));
      repeat (2) @(posedge CLK_IN);
      SYS_RST_IN <= 1'b0;
      foreach (r[i]) r[i] = 8'h00;
      check_all();
      for (int i = 0; i < 6; i++) read_check(i);
      for (int n = 0; n < 14; n++) begin
         foreach (r[i]) r[i] = 8'($urandom);
         if (n < 4) begin
            r[1][5:4] = 2'(n);
            r[2][7:6] = 2'(n);
            r[1][2:0] = 3'h6;
            r[0][3]   = n[0];
         end
         legalise();
         host_u.write_seq(VDC_DEV_WR_ADDR, 8'h00,
                          {r[0], r[1], r[2], r[3], r[4]}, ok);
         check(ok, 1'b1);
         check_all();
         read_check($urandom_range(4, 0));
      end
      r[3] = 8'h5A;
      r[4] = 8'h2B;
      host_u.write_seq(VDC_DEV_WR_ADDR, 8'h03, {r[3], r[4], 8'hFF}, ok);
      check(ok, 1'b1);
      check_all();
      read_check(5);
      host_u.write_seq(8'h8A, 8'h00, {8'hFF}, ok);
      check(ok, 1'b0);
      check_all();
      read_check(0);
      SYS_RST_IN <= 1'b1;
      @(posedge CLK_IN);
      SYS_RST_IN <= 1'b0;
      foreach (r[i]) r[i] = 8'h00;
      check_all();
      print_verdict();
   end
endmodule : video_decoder_config_regs_tb
